// file: bench/can_command_register_logic_bench.sv
`default_nettype none
`define chk(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module can_command_register_logic_bench import can_cmd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, stall = 1'b0;
  logic [3:0] address = 4'h0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] writedata = 32'h0, readdata, rdata;
  logic waitrequest, tx_busy, tx_done, tx_pending, rx_release, rx_enable, sleeping;
  logic wakeup_irq, reset_request, receiver_input_a, receiver_input_b;
  logic tx_complete_flag, rx_buffer_full_flag, overrun_flag;
  logic rx_msg_stored = 1'b0, overrun_event = 1'b0, can_irq_pending = 1'b0;
  logic activity_single = 1'b0, activity_diff = 1'b0, bus_free = 1'b0;
  logic bus_comparator_in_a = 1'b1, bus_comparator_in_b = 1'b1, half_ref_level = 1'b0;
  logic [7:0] rt_sw [4] = '{8'hc0, 8'h80, 8'h40, 8'h00};
  logic [2:0] rt_in [4] = '{3'b010, 3'b110, 3'b001, 3'b010};
  logic [1:0] rt_out [4] = '{2'b01, 2'b10, 2'b10, 2'b10};
  int n_errors = 0, compares = 0, n_wake = 0, n_rel = 0;

  always #12.5 mclk = ~mclk;

  can_command_ctrl i_dut (.mclk, .srst, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .tx_busy, .tx_done, .rx_msg_stored,
    .overrun_event, .can_irq_pending, .activity_single, .activity_diff, .bus_free,
    .bus_comparator_in_a, .bus_comparator_in_b, .half_ref_level, .tx_pending,
    .rx_release, .rx_enable, .sleeping, .wakeup_irq, .reset_request,
    .receiver_input_a, .receiver_input_b, .tx_complete_flag, .rx_buffer_full_flag,
    .overrun_flag);

  can_far_side_model i_far (.mclk, .srst, .tx_pending, .stall, .tx_busy, .tx_done);

  // Pulses counted per cycle, so a pulse held too long shows as extra counts
  always @(posedge mclk) begin
    if (wakeup_irq === 1'b1) n_wake++;
    if (rx_release === 1'b1) n_rel++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      @(posedge mclk);
      n++;
    end
    `chk(n, 1)
    rdata = readdata;
    write <= 1'b0;
    read <= 1'b0;
    #1;
  endtask : bus

  task automatic t_reset;
    bus(1'b0, CMD_ADDR, 8'h00);
    `chk(rdata, 32'h0000_00cf)
    bus(1'b0, STAT_ADDR, 8'h00);
    `chk(rdata, 32'h0000_000c)
    bus(1'b1, 4'hc, 8'hff);
    bus(1'b0, 4'hc, 8'h00);
    `chk(rdata, 32'h0)
    bus(1'b0, CMD_ADDR, 8'h00);
    `chk(rdata, 32'h0000_00cf)
    // A write without the low byte lane must leave the switches alone
    byteenable <= 4'he;
    bus(1'b1, CMD_ADDR, 8'h00);
    byteenable <= 4'h1;
    bus(1'b0, CMD_ADDR, 8'h00);
    `chk(rdata, 32'h0000_00cf)
    `chk(reset_request, 1'b1)
    bus(1'b1, CTRL_ADDR, 8'h00);
    `chk(reset_request, 1'b0)
    bus(1'b0, CTRL_ADDR, 8'h00);
    `chk(rdata, 32'h0)
    bus(1'b1, CTRL_ADDR, 8'h01);
    `chk(reset_request, 1'b1)
  endtask : t_reset

  task automatic t_tx;
    stall <= 1'b1;
    bus(1'b1, CMD_ADDR, 8'h01);
    `chk({tx_pending, tx_complete_flag}, 2'b10)
    bus(1'b1, CMD_ADDR, 8'h00);
    `chk(tx_pending, 1'b1)
    bus(1'b0, STAT_ADDR, 8'h00);
    `chk(rdata, 32'h0)
    bus(1'b1, CMD_ADDR, 8'h03);
    `chk(tx_pending, 1'b1)
    bus(1'b1, CMD_ADDR, 8'h02);
    `chk({tx_pending, tx_complete_flag}, 2'b00)
    bus(1'b0, STAT_ADDR, 8'h00);
    `chk(rdata, 32'h0000_0004)
    stall <= 1'b0;
    bus(1'b1, CMD_ADDR, 8'h01);
    bus(1'b1, CMD_ADDR, 8'h02);
    bus(1'b0, STAT_ADDR, 8'h00);
    `chk(rdata, 32'h0000_0020)
    cyc(6);
    `chk({tx_pending, tx_complete_flag}, 2'b01)
  endtask : t_tx

  task automatic t_rx;
    rx_msg_stored <= 1'b1;
    overrun_event <= 1'b1;
    cyc(1);
    rx_msg_stored <= 1'b0;
    overrun_event <= 1'b0;
    cyc(1);
    bus(1'b0, STAT_ADDR, 8'h00);
    `chk(rdata, 32'h0000_000f)
    bus(1'b1, CMD_ADDR, 8'h04);
    `chk({rx_release, rx_buffer_full_flag, overrun_flag}, 3'b101)
    cyc(3);
    `chk(rx_release, 1'b0)
    bus(1'b1, CMD_ADDR, 8'h0c);
    `chk(overrun_flag, 1'b0)
    cyc(2);
    `chk(n_rel, 2)
  endtask : t_rx

  task automatic t_route;
    for (int i = 0; i < 4; i++) begin
      // Inputs move after the switch write, so the 0,0 case really shows a hold
      bus(1'b1, CMD_ADDR, rt_sw[i]);
      {bus_comparator_in_a, bus_comparator_in_b, half_ref_level} <= rt_in[i];
      cyc(1);
      `chk({receiver_input_a, receiver_input_b}, rt_out[i])
      bus(1'b0, CMD_ADDR, 8'h00);
      `chk(rdata, {24'h0, rt_sw[i] | 8'h0f})
    end
  endtask : t_route

  task automatic t_sleep;
    can_irq_pending <= 1'b1;
    bus(1'b1, CMD_ADDR, 8'h10);
    cyc(4);
    `chk(sleeping, 1'b0)
    can_irq_pending <= 1'b0;
    cyc(4);
    `chk(sleeping, 1'b1)
    bus(1'b0, CMD_ADDR, 8'h00);
    `chk(rdata, 32'h0000_001f)
    // Differential mode must ignore the single-ended detector
    activity_single <= 1'b1;
    cyc(4);
    `chk(sleeping, 1'b1)
    activity_single <= 1'b0;
    bus(1'b1, CMD_ADDR, 8'h00);
    cyc(4);
    `chk({sleeping, rx_enable}, 2'b01)
    `chk(n_wake, 1)
    bus(1'b1, CMD_ADDR, 8'h30);
    cyc(4);
    activity_diff <= 1'b1;
    cyc(4);
    `chk(sleeping, 1'b1)
    activity_diff <= 1'b0;
    activity_single <= 1'b1;
    cyc(4);
    `chk(n_wake, 2)
    activity_single <= 1'b0;
    cyc(3);
    `chk({sleeping, rx_enable}, 2'b00)
    bus(1'b0, CMD_ADDR, 8'h00);
    `chk(rdata, 32'h0000_002f)
    bus_free <= 1'b1;
    cyc(2);
    bus_free <= 1'b0;
    `chk(rx_enable, 1'b1)
  endtask : t_sleep

  task automatic wrap_up;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    cyc(1);
    t_reset();
    t_tx();
    t_rx();
    t_route();
    t_sleep();
    wrap_up();
  end

  // Whole sequence needs about 124 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
endmodule : can_command_register_logic_bench
`default_nettype wire

// file: bench/can_far_side_model.sv
`default_nettype none
// Transfer layer stand-in: starts a pending frame unless stalled, stays busy
// four cycles, then reports one completion pulse.
module can_far_side_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic tx_pending,
  input wire logic stall,
  output logic tx_busy,
  output logic tx_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      tx_done <= 1'b0;
      if (!tx_busy && tx_pending && !stall) begin
        tx_busy <= 1'b1;
        cnt_q <= 3'h4;
      end else if (tx_busy) begin
        cnt_q <= cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          tx_busy <= 1'b0;
          tx_done <= 1'b1;
        end
      end
    end
  end
endmodule : can_far_side_model
`default_nettype wire

// file: verilog/can_cmd_pkg.sv
`default_nettype none
package can_cmd_pkg;
  // Word indices of the register map; byte address is four times the index
  localparam logic [1:0] CTRL_IDX = 2'h0;
  localparam logic [1:0] CMD_IDX = 2'h1;
  localparam logic [1:0] STAT_IDX = 2'h2;
  localparam logic [3:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
  localparam logic [3:0] CMD_ADDR = {CMD_IDX, 2'h0};
  localparam logic [3:0] STAT_ADDR = {STAT_IDX, 2'h0};
  // Command register fields
  localparam int TX_REQUEST_BIT = 0;
  localparam int ABORT_TX_BIT = 1;
  localparam int RELEASE_RX_BIT = 2;
  localparam int CLEAR_OVERRUN_BIT = 3;
  localparam int SLEEP_BIT = 4;
  localparam int WAKE_MODE_BIT = 5;
  localparam int SWITCH_B_BIT = 6;
  localparam int SWITCH_A_BIT = 7;
  localparam logic [3:0] CMD_LOW_READ = 4'hf;
  // Status register fields
  localparam int RX_FULL_BIT = 0;
  localparam int DO_BIT = 1;
  localparam int TX_FREE_BIT = 2;
  localparam int TX_DONE_BIT = 3;
  localparam int TS_BIT = 5;
  // Control register field
  localparam int RESET_REQ_BIT = 0;
  // Values after reset
  localparam logic RESET_REQ_INIT = 1'b1;
  localparam logic SWITCH_INIT = 1'b1;
  localparam logic WAKE_MODE_INIT = 1'b0;
  localparam logic TX_DONE_INIT = 1'b1;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // Least spacing the software keeps between two buffer releases
  localparam int RELEASE_GAP_CYCLES = 3;
  typedef enum logic [1:0] {ST_AWAKE, ST_ASLEEP, ST_WAIT_FREE} sleep_state_t;
endpackage : can_cmd_pkg
`default_nettype wire

// file: verilog/can_command_ctrl.sv
// How it works
// R1 - Command bits 0 to 3 always read back as one.
// R2 - Command register sits at word index 1, switches high, request low.
// R3 - Wake mode one uses single-ended detection, zero uses differential.
// R4 - Sleep entered only with sleep bit set, no interrupt, no activity.
// R5 - Wake on sleep bit clear or bus activity, pulse wake-up interrupt.
// R6 - After bus wake, receiving waits for a bus-free condition.
// R7 - Sleep bit reads the real sleep state.
// R8 - Writing one to clear-overrun clears the overrun flag.
// R9 - Software clears overrun only with the second buffer release.
// R10 - Writing one to release frees the presented receive buffer.
// R11 - Software releases a buffer after reading it.
// R12 - Software spaces two buffer releases by at least 3 cycles.
// R13 - Abort cancels a pending request not yet started.
// R14 - Writing one to request starts a transmission; zero does nothing.
// R15 - Writing zero never cancels a pending request; only abort does.
// R16 - Bits 7 and 6 read back the receive-input switch settings.
// R17 - Switch bits route comparator inputs or reference to receiver.
// R18 - Software writes wake mode together with the sleep bit.
// R19 - Software checks completion after abort once buffer is released.
// R20 - Request clears completion flag; it stays clear when aborted.
// R21 - Release clears buffer-full flag; a stored message sets it.
// R22 - Request, abort, release, clear-overrun act as one-cycle pulses.
`default_nettype none
module can_command_ctrl import can_cmd_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic tx_busy,
  input wire logic tx_done,
  input wire logic rx_msg_stored,
  input wire logic overrun_event,
  input wire logic can_irq_pending,
  input wire logic activity_single,
  input wire logic activity_diff,
  input wire logic bus_free,
  input wire logic bus_comparator_in_a,
  input wire logic bus_comparator_in_b,
  input wire logic half_ref_level,
  output logic tx_pending,
  output logic rx_release,
  output logic rx_enable,
  output logic sleeping,
  output logic wakeup_irq,
  output logic reset_request,
  output logic receiver_input_a,
  output logic receiver_input_b,
  output logic tx_complete_flag,
  output logic rx_buffer_full_flag,
  output logic overrun_flag
);
  logic wait_q;
  logic [31:0] rdata_q;
  logic reset_req_q;
  logic input_a_switch_on_q;
  logic input_b_switch_on_q;
  logic wakeup_detect_mode_q;
  logic sleep_request_q;
  logic tx_pending_q;
  logic rx_release_q;
  logic wake_irq_q;
  logic rx_a_q;
  logic rx_b_q;
  sleep_state_t state_q;
  sleep_state_t state_d;
  logic wr_ctrl;
  logic wr_cmd;
  logic tx_request_cmd;
  logic abort_tx_cmd;
  logic release_rx_buffer_cmd;
  logic clear_overrun_cmd;
  logic wake_activity;
  logic [7:0] status_byte;

  flag_if txc_f ();
  flag_if full_f ();
  flag_if do_f ();

  // One wait cycle per access, so read data always come from a flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else if ((read || write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign wr_ctrl = write && !wait_q && address == CTRL_ADDR && byteenable[0];
  assign wr_cmd = write && !wait_q && address == CMD_ADDR && byteenable[0]; // R2

  // Commands exist only in the accepting cycle; nothing is retained
  assign tx_request_cmd = wr_cmd && writedata[TX_REQUEST_BIT]; // R22
  assign abort_tx_cmd = wr_cmd && writedata[ABORT_TX_BIT]; // R22
  assign release_rx_buffer_cmd = wr_cmd && writedata[RELEASE_RX_BIT]; // R22
  assign clear_overrun_cmd = wr_cmd && writedata[CLEAR_OVERRUN_BIT]; // R22

  assign status_byte = {2'h0, tx_busy, 1'b0, txc_f.q,
                        !tx_pending_q && !tx_busy, do_f.q, full_f.q};

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= READ_ZERO;
    end else if (read && wait_q) begin
      if (address == CTRL_ADDR) begin
        rdata_q <= {31'h0, reset_req_q};
      end else if (address == CMD_ADDR) begin
        rdata_q <= {24'h0, input_a_switch_on_q, input_b_switch_on_q, // R16
                    wakeup_detect_mode_q, state_q == ST_ASLEEP, // R7
                    CMD_LOW_READ}; // R1
      end else if (address == STAT_ADDR) begin
        rdata_q <= {24'h0, status_byte};
      end else begin
        rdata_q <= READ_ZERO;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reset_req_q <= RESET_REQ_INIT;
    end else if (wr_ctrl) begin
      reset_req_q <= writedata[RESET_REQ_BIT];
    end
  end

  // Switches take effect at any time; software is advised to move
  // them only under reset request, the hardware does not enforce it
  always_ff @(posedge mclk) begin
    if (srst) begin
      input_a_switch_on_q <= SWITCH_INIT;
      input_b_switch_on_q <= SWITCH_INIT;
      wakeup_detect_mode_q <= WAKE_MODE_INIT;
    end else if (wr_cmd) begin
      input_a_switch_on_q <= writedata[SWITCH_A_BIT];
      input_b_switch_on_q <= writedata[SWITCH_B_BIT];
      wakeup_detect_mode_q <= writedata[WAKE_MODE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_pending_q <= 1'b0;
    end else if (tx_request_cmd) begin
      tx_pending_q <= 1'b1; // R14
    end else if (abort_tx_cmd && !tx_busy) begin
      tx_pending_q <= 1'b0; // R13
    end else if (tx_busy) begin
      tx_pending_q <= 1'b0;
    end
  end

  assign txc_f.set = tx_done;
  assign txc_f.clr = tx_request_cmd; // R20
  sticky_flag #(.RESET_VAL(TX_DONE_INIT)) u_txc (.mclk(mclk), .srst(srst), .f(txc_f));

  assign full_f.set = rx_msg_stored; // R21
  assign full_f.clr = release_rx_buffer_cmd; // R21
  sticky_flag #(.RESET_VAL(1'b0)) u_full (.mclk(mclk), .srst(srst), .f(full_f));

  assign do_f.set = overrun_event;
  assign do_f.clr = clear_overrun_cmd; // R8
  sticky_flag #(.RESET_VAL(1'b0)) u_do (.mclk(mclk), .srst(srst), .f(do_f));

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_release_q <= 1'b0;
    end else begin
      rx_release_q <= release_rx_buffer_cmd; // R10
    end
  end

  assign wake_activity = wakeup_detect_mode_q ? activity_single : activity_diff; // R3

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_AWAKE: begin
        if (sleep_request_q && !can_irq_pending && !wake_activity) begin
          state_d = ST_ASLEEP; // R4
        end
      end
      ST_ASLEEP: begin
        if (wake_activity) begin
          state_d = ST_WAIT_FREE; // R5
        end else if (!sleep_request_q) begin
          state_d = ST_AWAKE; // R5
        end
      end
      ST_WAIT_FREE: begin
        if (bus_free) begin
          state_d = ST_AWAKE; // R6
        end
      end
      default: begin
        state_d = ST_AWAKE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  // A bus wake drops the request so the block does not sleep again at once
  always_ff @(posedge mclk) begin
    if (srst) begin
      sleep_request_q <= 1'b0;
    end else if (wr_cmd) begin
      sleep_request_q <= writedata[SLEEP_BIT];
    end else if (state_q == ST_ASLEEP && wake_activity) begin
      sleep_request_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_irq_q <= 1'b0;
    end else begin
      wake_irq_q <= state_q == ST_ASLEEP && state_d != ST_ASLEEP; // R5
    end
  end

  // 0,0 keeps the last levels: the switches take no action
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_a_q <= 1'b1;
      rx_b_q <= 1'b1;
    end else if (input_a_switch_on_q && input_b_switch_on_q) begin
      rx_a_q <= bus_comparator_in_a; // R17
      rx_b_q <= bus_comparator_in_b; // R17
    end else if (input_a_switch_on_q) begin
      rx_a_q <= bus_comparator_in_a; // R17
      rx_b_q <= half_ref_level; // R17
    end else if (input_b_switch_on_q) begin
      rx_a_q <= half_ref_level;
      rx_b_q <= bus_comparator_in_b;
    end
  end

  logic rx_enable_q;
  logic sleeping_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_enable_q <= 1'b1;
      sleeping_q <= 1'b0;
    end else begin
      rx_enable_q <= state_d == ST_AWAKE; // R6
      sleeping_q <= state_d == ST_ASLEEP;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign tx_pending = tx_pending_q;
  assign rx_release = rx_release_q;
  assign rx_enable = rx_enable_q;
  assign sleeping = sleeping_q;
  assign wakeup_irq = wake_irq_q;
  assign reset_request = reset_req_q;
  assign receiver_input_a = rx_a_q;
  assign receiver_input_b = rx_b_q;
  assign tx_complete_flag = txc_f.q;
  assign rx_buffer_full_flag = full_f.q;
  assign overrun_flag = do_f.q;

  sequence s_bus_wake;
    state_q == ST_ASLEEP && wake_activity;
  endsequence

  sequence s_wake_then_blocked;
    wakeup_irq && !rx_enable ##1 (!rx_enable || $past(bus_free));
  endsequence

  sequence s_release_pulse;
    rx_release ##1 !rx_release;
  endsequence

  chk_low_bits_one: assert property ( // R1
    @(posedge mclk) disable iff (srst)
    (read && !waitrequest && address == CMD_ADDR) |-> readdata[3:0] == 4'hf)
    else $error("command low bits did not read as ones");

  chk_sleep_readback: assert property ( // R7
    @(posedge mclk) disable iff (srst)
    (read && !waitrequest && address == CMD_ADDR) |->
      readdata[SLEEP_BIT] == $past(sleeping))
    else $error("sleep bit did not show the sleep state");

  chk_tx_request_set: assert property ( // R14
    @(posedge mclk) disable iff (srst)
    tx_request_cmd |=> tx_pending && (!tx_complete_flag || $past(tx_done)))
    else $error("request did not become pending");

  chk_zero_keeps_request: assert property ( // R15
    @(posedge mclk) disable iff (srst)
    (tx_pending && wr_cmd && !writedata[TX_REQUEST_BIT] && !writedata[ABORT_TX_BIT]
     && !tx_busy) |=> tx_pending)
    else $error("writing zero cancelled a request");

  chk_abort_idle: assert property ( // R13
    @(posedge mclk) disable iff (srst)
    (abort_tx_cmd && !tx_request_cmd && !tx_busy) |=> !tx_pending)
    else $error("abort did not withdraw the request");

  chk_tcs_stays_low: assert property ( // R20
    @(posedge mclk) disable iff (srst)
    (abort_tx_cmd && !tx_request_cmd && tx_pending && !tx_busy && !tx_complete_flag
     && !tx_done) |=> !tx_complete_flag && !tx_pending)
    else $error("completion set after an aborted request");

  chk_release_once: assert property ( // R10
    @(posedge mclk) disable iff (srst)
    release_rx_buffer_cmd |=> s_release_pulse)
    else $error("release pulse not exactly one cycle");

  chk_rbs_update: assert property ( // R21
    @(posedge mclk) disable iff (srst)
    (release_rx_buffer_cmd || rx_msg_stored) |=> rx_buffer_full_flag == $past(rx_msg_stored))
    else $error("buffer-full flag wrong after release or store");

  chk_overrun_clear: assert property ( // R8
    @(posedge mclk) disable iff (srst)
    (clear_overrun_cmd && !overrun_event) |=> !overrun_flag)
    else $error("overrun flag not cleared");

  chk_sleep_entry: assert property ( // R4
    @(posedge mclk) disable iff (srst)
    $rose(sleeping) |->
      $past(sleep_request_q) && !$past(can_irq_pending) && !$past(wake_activity))
    else $error("sleep entered with activity or interrupt");

  chk_bus_wake: assert property ( // R6
    @(posedge mclk) disable iff (srst)
    s_bus_wake |=> s_wake_then_blocked)
    else $error("bus wake did not interrupt and hold off receiving");

  chk_switch_route: assert property ( // R17
    @(posedge mclk) disable iff (srst)
    (input_a_switch_on_q && !input_b_switch_on_q) |=>
      receiver_input_a == $past(bus_comparator_in_a) &&
      receiver_input_b == $past(half_ref_level))
    else $error("switch routing wrong for 1,0");
endmodule : can_command_ctrl
`default_nettype wire

// file: verilog/flag_if.sv
`default_nettype none
interface flag_if;
  logic set;
  logic clr;
  logic q;
  modport ctrl (output set, output clr, input q);
  modport flag (input set, input clr, output q);
endinterface : flag_if
`default_nettype wire

// file: verilog/sticky_flag.sv
`default_nettype none
module sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic srst,
  flag_if.flag f
);
  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge mclk) begin
    if (srst) begin
      f.q <= RESET_VAL;
    end else if (f.set) begin
      f.q <= 1'b1;
    end else if (f.clr) begin
      f.q <= 1'b0;
    end
  end
endmodule : sticky_flag
`default_nettype wire
